// File: pcmds_ds_tx.sv
module pcmds_ds_tx
    import pcmds_pkg::*;
(
    input  wire logic              clock_i,
    output pcmds_pkg::pcmds_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial pins_o = '0;

    // ****************************************
    // sender tasks
    // ****************************************
    // lines are levels: they hold between bits, like a real sender
    task automatic send_bit(input logic b);
        @(posedge clock_i);
        if (pins_o.data != b) begin
            pins_o.data <= b;
        end else begin
            pins_o.strobe <= ~pins_o.strobe;
        end
    endtask

    // both lines at once is illegal coding, used to probe refusal
    task automatic send_both;
        @(posedge clock_i);
        pins_o <= ~pins_o;
    endtask
endmodule

// File: pcmds_pkg.sv
package pcmds_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_INT_ENABLE  = 8'h00;
    localparam logic [7:0]  OFS_INT_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_DS_CONTROL  = 8'h08;
    localparam logic [7:0]  OFS_THRESHOLD   = 8'h0C;
    localparam logic [7:0]  OFS_RX_DATA     = 8'h10;

    // ****************************************
    // interrupt bit positions
    // ****************************************
    localparam int          IRQ_TX_LEVEL    = 0;
    localparam int          IRQ_RX_LEVEL    = 1;
    localparam int          IRQ_TX_ERROR    = 2;
    localparam int          IRQ_RX_ERROR    = 3;
    localparam int          IRQ_BITS        = 4;
    localparam logic [3:0]  IRQ_RESET       = 4'h0;

    // ****************************************
    // data/strobe control fields
    // ****************************************
    localparam int          DS_EN_BIT       = 0;
    localparam int          DS_RESET_BIT    = 1;
    localparam int          DS_FLUSH_BIT    = 2;
    localparam int          DS_LEVEL_LSB    = 4;
    localparam int          DS_FLUSHED_LSB  = 10;
    localparam int          DS_WORDS_LSB    = 16;
    localparam int          CNT_W           = 6;
    localparam int          WORD_BITS       = 32;
    localparam logic [5:0]  CNT_FULL        = 6'h20;
    localparam logic [5:0]  CNT_RESET       = 6'h00;

    // ****************************************
    // threshold register fields
    // ****************************************
    localparam int          RX_THR_LSB      = 0;
    localparam int          TX_THR_LSB      = 8;
    localparam logic [5:0]  THR_RESET       = 6'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } pcmds_bus_req_t;

    typedef struct packed {
        logic data;
        logic strobe;
    } pcmds_pins_t;

endpackage

// File: pcmds_rx.sv
module pcmds_rx #(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic                      clock_i,
    input  wire logic                      arst_n_i,
    input  wire pcmds_pkg::pcmds_bus_req_t bus_i,
    output logic [31:0]                    rdata_o,
    input  wire pcmds_pkg::pcmds_pins_t    pins_i,
    input  wire logic [5:0]                tx_fifo_level_i,
    input  wire logic                      tx_fifo_error_i,
    output logic                           irq_o
);
    import pcmds_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);

    // ****************************************
    // state
    // ****************************************
    logic [3:0]          int_enable;
    logic [3:0]          int_status;
    logic                ds_enable;
    logic                ds_logic_reset;
    logic                flush_pending;
    logic [5:0]          rx_irq_threshold;
    logic [5:0]          tx_irq_threshold;
    logic [CNT_W-1:0]    rx_buffer_bit_count;
    logic [CNT_W-1:0]    flushed_count;
    logic [WORD_BITS-1:0] rx_buffer;
    logic                data_prev;
    logic                strobe_prev;
    logic [PTR_W-1:0]    wr_ptr;
    logic [PTR_W-1:0]    rd_ptr;
    logic [CNT_W-1:0]    rx_fifo_word_count;
    logic [31:0]         rdata;
    logic [31:0]         fifo_mem [FIFO_DEPTH];

    logic [3:0]          next_int_enable;
    logic [3:0]          next_int_status;
    logic                next_ds_enable;
    logic                next_ds_logic_reset;
    logic                next_flush_pending;
    logic [5:0]          next_rx_irq_threshold;
    logic [5:0]          next_tx_irq_threshold;
    logic [CNT_W-1:0]    next_rx_buffer_bit_count;
    logic [CNT_W-1:0]    next_flushed_count;
    logic [WORD_BITS-1:0] next_rx_buffer;
    logic                next_data_prev;
    logic                next_strobe_prev;
    logic [PTR_W-1:0]    next_wr_ptr;
    logic [PTR_W-1:0]    next_rd_ptr;
    logic [CNT_W-1:0]    next_rx_fifo_word_count;
    logic [31:0]         next_rdata;

    logic                wr_hit_en;
    logic                wr_hit_st;
    logic                wr_hit_ds;
    logic                wr_hit_thr;
    logic                rd_pop;
    logic                new_bit;
    logic                fifo_full;
    logic                fifo_empty;
    logic                push;
    logic                do_pop;
    logic [WORD_BITS-1:0] assembled;
    logic [CNT_W-1:0]    assembled_cnt;
    logic [3:0]          events;
    logic [31:0]         ds_readback;

    // ****************************************
    // register control
    // ****************************************
    always_comb begin
        wr_hit_en  = bus_i.wr && (bus_i.addr == OFS_INT_ENABLE);
        wr_hit_st  = bus_i.wr && (bus_i.addr == OFS_INT_STATUS);
        wr_hit_ds  = bus_i.wr && (bus_i.addr == OFS_DS_CONTROL);
        wr_hit_thr = bus_i.wr && (bus_i.addr == OFS_THRESHOLD);
        rd_pop     = bus_i.rd && (bus_i.addr == OFS_RX_DATA);
        fifo_full  = (rx_fifo_word_count == CNT_W'(FIFO_DEPTH));
        fifo_empty = (rx_fifo_word_count == CNT_W'(0));

        next_int_enable       = int_enable;
        next_ds_enable        = ds_enable;
        next_ds_logic_reset   = ds_logic_reset;
        next_rx_irq_threshold = rx_irq_threshold;
        next_tx_irq_threshold = tx_irq_threshold;
        // enables are assumed static while the interface is running
        if (wr_hit_en) begin
            next_int_enable = bus_i.wdata[IRQ_BITS-1:0];
        end
        if (wr_hit_ds) begin
            next_ds_enable      = bus_i.wdata[DS_EN_BIT];
            next_ds_logic_reset = bus_i.wdata[DS_RESET_BIT];
        end
        if (wr_hit_thr) begin
            next_rx_irq_threshold = bus_i.wdata[RX_THR_LSB +: 6];
            next_tx_irq_threshold = bus_i.wdata[TX_THR_LSB +: 6];
        end
    end

    // ****************************************
    // data/strobe receive buffer
    // ****************************************
    // a bit is a change on exactly one line; a pair that flips together
    // in one cycle is dropped, since the order of the two changes on
    // the wire cannot be told apart at this clock
    always_comb begin
        // edge detect on the registered pin copies
        next_data_prev   = pins_i.data;
        next_strobe_prev = pins_i.strobe;
        new_bit = ds_enable && !ds_logic_reset &&
                  ((pins_i.data ^ data_prev) ^
                   (pins_i.strobe ^ strobe_prev));

        assembled     = rx_buffer;
        assembled_cnt = rx_buffer_bit_count;
        if (new_bit) begin
            assembled[rx_buffer_bit_count[4:0]] = pins_i.data;
            assembled_cnt = rx_buffer_bit_count + CNT_W'(1);
        end

        next_rx_buffer           = assembled;
        next_rx_buffer_bit_count = assembled_cnt;
        next_flushed_count       = flushed_count;
        next_flush_pending       = flush_pending;
        push                     = 1'b0;
        // a bit arriving with the flush is included in the flushed word
        if (flush_pending) begin
            push                     = (assembled_cnt != CNT_RESET);
            next_flushed_count       = assembled_cnt;
            next_rx_buffer           = '0;
            next_rx_buffer_bit_count = CNT_RESET;
            next_flush_pending       = 1'b0;
        end else if (assembled_cnt == CNT_FULL) begin
            push                     = 1'b1;
            next_rx_buffer           = '0;
            next_rx_buffer_bit_count = CNT_RESET;
        end
        if (wr_hit_ds && bus_i.wdata[DS_FLUSH_BIT]) begin
            next_flush_pending = 1'b1;
        end
        if (ds_logic_reset) begin
            push                     = 1'b0;
            next_rx_buffer           = '0;
            next_rx_buffer_bit_count = CNT_RESET;
            next_flush_pending       = 1'b0;
            next_flushed_count       = CNT_RESET;
        end
    end

    // ****************************************
    // rx fifo pointers and level
    // ****************************************
    // the level counter is kept beside the pointers so full and empty
    // never rest on a compare of wrapped pointers; a push and a pop in
    // one cycle leave the level unchanged unless it is full or empty
    always_comb begin
        // a push into a full fifo drops the word and flags an error
        do_pop      = rd_pop && !fifo_empty;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push && !fifo_full) begin
            next_wr_ptr = (wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ?
                          '0 : wr_ptr + PTR_W'(1);
        end
        if (do_pop) begin
            next_rd_ptr = (rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ?
                          '0 : rd_ptr + PTR_W'(1);
        end
        next_rx_fifo_word_count = rx_fifo_word_count
            + CNT_W'(push && !fifo_full) - CNT_W'(do_pop);
    end

    // ****************************************
    // interrupt status
    // ****************************************
    // level events re-set every cycle while their condition holds, so a
    // write-one clear only sticks once the level has moved past the
    // threshold
    always_comb begin
        events = '0;
        events[IRQ_RX_ERROR] = (push && fifo_full)
                             || (rd_pop && fifo_empty);
        events[IRQ_TX_ERROR] = tx_fifo_error_i;
        events[IRQ_RX_LEVEL] =
            (rx_fifo_word_count >= rx_irq_threshold);
        events[IRQ_TX_LEVEL] =
            (tx_fifo_level_i < tx_irq_threshold);

        // set wins over a simultaneous write-one clear
        next_int_status = int_status;
        if (wr_hit_st) begin
            next_int_status = int_status
                            & ~bus_i.wdata[IRQ_BITS-1:0];
        end
        next_int_status = next_int_status | events;
    end

    // ****************************************
    // register read-back
    // ****************************************
    // read data is zero outside the answer cycle, so a late sample
    // shows nothing stale
    always_comb begin
        ds_readback = '0;
        ds_readback[DS_EN_BIT]    = ds_enable;
        ds_readback[DS_RESET_BIT] = ds_logic_reset;
        ds_readback[DS_FLUSH_BIT] = 1'b0;
        ds_readback[DS_LEVEL_LSB +: CNT_W]   = rx_buffer_bit_count;
        ds_readback[DS_FLUSHED_LSB +: CNT_W] = flushed_count;
        ds_readback[DS_WORDS_LSB +: CNT_W]   = rx_fifo_word_count;

        next_rdata = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_INT_ENABLE: next_rdata[IRQ_BITS-1:0] = int_enable;
                OFS_INT_STATUS: next_rdata[IRQ_BITS-1:0] = int_status;
                OFS_DS_CONTROL: next_rdata = ds_readback;
                OFS_THRESHOLD: begin
                    next_rdata[RX_THR_LSB +: 6] = rx_irq_threshold;
                    next_rdata[TX_THR_LSB +: 6] = tx_irq_threshold;
                end
                OFS_RX_DATA: next_rdata = fifo_empty ? '0 : fifo_mem[rd_ptr];
                default: next_rdata = '0;
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // the enables are not fenced off while the mode runs; keeping them
    // static then is left to the driver
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_enable       <= IRQ_RESET;
            ds_enable        <= 1'b0;
            ds_logic_reset   <= 1'b0;
            rx_irq_threshold <= THR_RESET;
            tx_irq_threshold <= THR_RESET;
        end else begin
            int_enable       <= next_int_enable;
            ds_enable        <= next_ds_enable;
            ds_logic_reset   <= next_ds_logic_reset;
            rx_irq_threshold <= next_rx_irq_threshold;
            tx_irq_threshold <= next_tx_irq_threshold;
        end
    end

    // ****************************************
    // data/strobe receive state
    // ****************************************
    // pin history runs even while disabled, so turning the mode on
    // never turns a stale line level into a bit
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flush_pending       <= 1'b0;
            rx_buffer_bit_count <= CNT_RESET;
            flushed_count       <= CNT_RESET;
            rx_buffer           <= '0;
            data_prev           <= 1'b0;
            strobe_prev         <= 1'b0;
        end else begin
            flush_pending       <= next_flush_pending;
            rx_buffer_bit_count <= next_rx_buffer_bit_count;
            flushed_count       <= next_flushed_count;
            rx_buffer           <= next_rx_buffer;
            data_prev           <= next_data_prev;
            strobe_prev         <= next_strobe_prev;
        end
    end

    // ****************************************
    // rx fifo state
    // ****************************************
    // pointers wrap at the depth itself, so a depth that is not a power
    // of two also works, at the cost of a compare per pointer
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr             <= '0;
            rd_ptr             <= '0;
            rx_fifo_word_count <= CNT_RESET;
        end else begin
            wr_ptr             <= next_wr_ptr;
            rd_ptr             <= next_rd_ptr;
            rx_fifo_word_count <= next_rx_fifo_word_count;
        end
    end

    // ****************************************
    // interrupt state
    // ****************************************
    // set and clear are merged above, so this only holds the result;
    // a clear racing an event loses
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_status <= IRQ_RESET;
        end else begin
            int_status <= next_int_status;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // registered so the answer stands for the whole cycle after the
    // strobe and no longer
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // rx fifo storage
    // ****************************************
    // no reset on the array: contents are only read behind the count
    always_ff @(posedge clock_i) begin
        if (push && !fifo_full) begin
            fifo_mem[wr_ptr] <= assembled;
        end
    end

    assign rdata_o = rdata;
    assign irq_o   = |(int_status & int_enable);

endmodule

// File: pcmds_rx_monitor.sv
module pcmds_rx_monitor
    import pcmds_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      arst_n_i,
    input  wire pcmds_pkg::pcmds_bus_req_t bus_i,
    input  wire logic [31:0]               rdata_o,
    input  wire pcmds_pkg::pcmds_pins_t    pins_i,
    input  wire logic [5:0]                tx_fifo_level_i,
    input  wire logic                      tx_fifo_error_i,
    input  wire logic                      irq_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // shadows of software writes
    // ****************************************
    logic [3:0] en_q;
    logic [5:0] tthr_q;
    logic [5:0] rthr_q;
    logic       clr_q;
    logic       irq_wr;

    assign irq_wr = bus_i.wr && (bus_i.addr == OFS_INT_ENABLE
                    || bus_i.addr == OFS_INT_STATUS);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q   <= 4'h0;
            tthr_q <= 6'h00;
            rthr_q <= 6'h00;
            clr_q  <= 1'b0;
        end else if (bus_i.wr) begin
            if (bus_i.addr == OFS_INT_ENABLE) en_q <= bus_i.wdata[3:0];
            if (bus_i.addr == OFS_THRESHOLD) begin
                rthr_q <= bus_i.wdata[5:0];
                tthr_q <= bus_i.wdata[13:8];
            end
            if (bus_i.addr == OFS_DS_CONTROL) clr_q <= bus_i.wdata[1];
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_ctl_read;
        bus_i.rd && bus_i.addr == OFS_DS_CONTROL;
    endsequence

    // ****************************************
    // checks
    // ****************************************
    chk_read_idle: assert property (!bus_i.rd |=> rdata_o == 32'h0)
        else $error("read data not zero without read");
    chk_flush_reads_zero: assert property (
        s_ctl_read |=> !rdata_o[DS_FLUSH_BIT])
        else $error("flush bit read back as one");
    chk_clear_holds_count: assert property (
        s_ctl_read ##0 (clr_q && $past(clr_q)) |=> rdata_o[9:4] == 6'h00)
        else $error("bit count moved while logic reset");
    chk_irq_masked_off: assert property (en_q == 4'h0 |-> !irq_o)
        else $error("interrupt with all enables clear");
    chk_irq_sticky_hold: assert property (irq_o && !irq_wr |=> irq_o)
        else $error("interrupt dropped without clear");
    chk_tx_level_irq: assert property (
        en_q[0] && !irq_wr && tx_fifo_level_i < tthr_q |=> irq_o)
        else $error("tx level below threshold gave no interrupt");
    chk_tx_error_irq: assert property (
        en_q[2] && !irq_wr && tx_fifo_error_i |=> irq_o)
        else $error("tx error gave no interrupt");
    chk_rx_level_irq: assert property (
        en_q[1] && !irq_wr && rthr_q == 6'h00 |=> irq_o)
        else $error("rx level at threshold gave no interrupt");
endmodule

bind pcmds_rx pcmds_rx_monitor u_mon (
    .clock_i         (clock_i),
    .arst_n_i        (arst_n_i),
    .bus_i           (bus_i),
    .rdata_o         (rdata_o),
    .pins_i          (pins_i),
    .tx_fifo_level_i (tx_fifo_level_i),
    .tx_fifo_error_i (tx_fifo_error_i),
    .irq_o           (irq_o)
);

// File: test_pcmds_irq_data_strobe_rx.sv
module test_pcmds_irq_data_strobe_rx
    import pcmds_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic           clock_i;
    logic           arst_n_i;
    pcmds_bus_req_t bus;
    logic [31:0]    rdata;
    pcmds_pins_t    pins;
    logic [5:0]     tx_level;
    logic           tx_err;
    logic           irq;
    logic [31:0]    v;
    int             fail_count;
    int             num_checks;

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    pcmds_rx DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .bus_i(bus),
        .rdata_o(rdata), .pins_i(pins), .tx_fifo_level_i(tx_level),
        .tx_fifo_error_i(tx_err), .irq_o(irq));
    pcmds_ds_tx u_tx (.clock_i(clock_i), .pins_o(pins));

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask

    // read data exist only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        bus.addr <= a; bus.rd <= 1'b1;
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic send_word(input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            if (i == 7) u_tx.send_both();
            u_tx.send_bit(w[i]);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(OFS_INT_ENABLE); check(v, 32'h0);
        rd(OFS_INT_STATUS); check(v, 32'h2);
        rd(OFS_DS_CONTROL); check(v, 32'h0);
        rd(8'h40); check(v, 32'h0);
        wr(OFS_INT_ENABLE, 32'h2); #1 check({31'h0, irq}, 32'h1);
        wr(OFS_INT_ENABLE, 32'h0); #1 check({31'h0, irq}, 32'h0);
    endtask

    task automatic t_tx_level;
        wr(OFS_THRESHOLD, 32'h500); tx_level <= 6'h05;
        wr(OFS_INT_STATUS, 32'hF); rd(OFS_INT_STATUS);
        check(v, 32'h2);
        rd(OFS_THRESHOLD); check(v, 32'h500);
        @(posedge clock_i) tx_level <= 6'h04;
        wr(OFS_INT_ENABLE, 32'h1); tx_level <= 6'h05;
        #1 check({31'h0, irq}, 32'h1);
        wr(OFS_INT_STATUS, 32'h0); #1 check({31'h0, irq}, 32'h1);
        wr(OFS_INT_STATUS, 32'h1); #1 check({31'h0, irq}, 32'h0);
    endtask

    task automatic t_tx_error;
        wr(OFS_INT_ENABLE, 32'h4);
        @(posedge clock_i) tx_err <= 1'b1;
        @(posedge clock_i) tx_err <= 1'b0;
        #1 check({31'h0, irq}, 32'h1);
        rd(OFS_INT_STATUS); check(v & 32'h4, 32'h4);
        wr(OFS_INT_STATUS, 32'h4); wr(OFS_INT_ENABLE, 32'h0);
    endtask

    task automatic t_rx_word;
        wr(OFS_THRESHOLD, 32'h1); wr(OFS_DS_CONTROL, 32'h1);
        wr(OFS_INT_STATUS, 32'hF);
        rd(OFS_INT_STATUS); check(v, 32'h0);
        send_word(32'hA5C30F96, 32);
        rd(OFS_DS_CONTROL); check(v, 32'h10001);
        rd(OFS_INT_STATUS); check(v, 32'h2);
        rd(OFS_RX_DATA); check(v, 32'hA5C30F96);
        rd(OFS_DS_CONTROL); check(v, 32'h1);
    endtask

    task automatic t_flush;
        send_word(32'h16, 5);
        rd(OFS_DS_CONTROL); check(v, 32'h51);
        wr(OFS_DS_CONTROL, 32'h5);
        rd(OFS_DS_CONTROL); check(v & 32'h4, 32'h0);
        rd(OFS_DS_CONTROL); check(v, 32'h11401);
        rd(OFS_RX_DATA); check(v, 32'h16);
    endtask

    task automatic t_clear;
        send_word(32'h7, 3);
        wr(OFS_DS_CONTROL, 32'h3); u_tx.send_bit(1'b0);
        rd(OFS_DS_CONTROL); check(v, 32'h3);
        wr(OFS_DS_CONTROL, 32'h1); u_tx.send_bit(1'b1);
        rd(OFS_DS_CONTROL); check(v, 32'h11);
    endtask

    task automatic t_rx_error;
        wr(OFS_DS_CONTROL, 32'h0); wr(OFS_INT_ENABLE, 32'h8);
        rd(OFS_RX_DATA); check(v, 32'h0);
        @(posedge clock_i) #1 check({31'h0, irq}, 32'h1);
        rd(OFS_INT_STATUS); check(v & 32'h8, 32'h8);
    endtask

    task automatic print_verdict;
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        bus = '0; tx_level = 6'h00; tx_err = 1'b0; arst_n_i = 1'b0;
        fail_count = 0; num_checks = 0;
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        t_reset(); t_tx_level(); t_tx_error(); t_rx_word();
        t_flush(); t_clear(); t_rx_error();
        print_verdict();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        fail_count++;
        print_verdict();
    end
endmodule
